/* File: hw/counter_compare_flags_defs.vh */
// Constants for the two-channel pulse counter status and command block.
// Assumes a 10 MHz core clock and an APB register port with 32-bit data.
`ifndef COUNTER_COMPARE_FLAGS_DEFS_VH
`define COUNTER_COMPARE_FLAGS_DEFS_VH

// Register byte offsets
`define CCF_CTRL_OFS      8'h00
`define CCF_POINT1_OFS    8'h04
`define CCF_POINT2_OFS    8'h08
`define CCF_STATUS_OFS    8'h0C
`define CCF_HOLDERR_OFS   8'h10

// Command bit positions in CTRL
`define CCF_CMD_MEAS1     0
`define CCF_CMD_FCLR1     1
`define CCF_CMD_FCLR2     2
`define CCF_CMD_MCLR1     3
`define CCF_CMD_MCLR2     4
`define CCF_CMD_ZCLR2     5
`define CCF_CMD_W         6

// Status bit positions in STATUS
`define CCF_ST_ABOVE1     0
`define CCF_ST_MATCH1     1
`define CCF_ST_BELOW1     2
`define CCF_ST_ABOVE2     3
`define CCF_ST_MATCH2     4
`define CCF_ST_BELOW2     5
`define CCF_ST_ZSEEN      6
`define CCF_ST_FAULT      7
`define CCF_ST_WARN       8
`define CCF_ST_W          9

// Reset values
`define CCF_CTRL_RST      6'h00
`define CCF_POINT_RST     32'h00000000

// Timing: least command hold time and core clock rate
`define CCF_HOLD_US       2000
`define CCF_CLK_MHZ       10
`define CCF_HOLD_CYC      (`CCF_HOLD_US * `CCF_CLK_MHZ)

`endif

/* File: hw/cmp_point.v */
// One coincidence point: above, match and below flags for one setpoint.
// Assumes value and point are on the core clock and scanEnd is a pulse.
`timescale 1ns/1ps
module cmp_point #(
  parameter CNT_W = 32
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             resetn,
  // Counter side
  input  wire [CNT_W-1:0] curValue,
  input  wire [CNT_W-1:0] pointValue,
  input  wire             scanEnd,
  // Command side
  input  wire             matchClear,
  // Flags
  output reg              aboveFlag,
  output reg              matchFlag,
  output reg              belowFlag
);

  wire isAbove = curValue > pointValue;
  wire isEqual = curValue == pointValue;
  wire isBelow = curValue < pointValue;

  // Magnitude flags only move at scan end; match follows at once
  always @(posedge core_clk) begin
    if (!resetn) begin
      aboveFlag <= 1'b0;
      matchFlag <= 1'b0;
      belowFlag <= 1'b0;
    end else begin
      if (scanEnd) begin
        aboveFlag <= isAbove;
        belowFlag <= isBelow;
      end
      // Set wins so a hit in the clearing cycle is kept
      if (isEqual)
        matchFlag <= 1'b1;
      else if (matchClear)
        matchFlag <= 1'b0;
    end
  end

endmodule // cmp_point

/* File: hw/counter_compare_flags.v */
// Status flags and command bits of a two-channel pulse counter, APB side.
// Assumes counter value, fault and warning causes and scanEnd are on
// core_clk; the phase-Z pin is asynchronous and is synchronised here.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "counter_compare_flags_defs.vh"
module counter_compare_flags #(
  parameter CNT_W    = 32,
  parameter HOLD_CYC = `CCF_HOLD_CYC
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             resetn,
  // APB slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  // Counter core, channel 2
  input  wire [CNT_W-1:0] ch2CountValue,
  input  wire             ch2FaultCause,
  input  wire             ch2WarnCause,
  input  wire             ch2ZPhasePin,
  input  wire             scanEnd,
  // Channel 1 controls
  output reg              ch1MeasureRun,
  output reg              ch1FaultClearPulse,
  // Channel 2 flags
  output wire             ch2AbovePoint1Flag,
  output wire             ch2MatchPoint1Flag,
  output wire             ch2BelowPoint1Flag,
  output wire             ch2AbovePoint2Flag,
  output wire             ch2MatchPoint2Flag,
  output wire             ch2BelowPoint2Flag,
  output reg              ch2ZPhasePresetSeenFlag,
  output reg              ch2FaultFlag,
  output reg              ch2WarningFlag
);

  localparam CW = `CCF_CMD_W;
  localparam HW = 16;
  localparam [HW-1:0] HOLD_MAX = HOLD_CYC[HW-1:0];

  // Point reset value cut to the counter width on purpose
  localparam [31:0]      POINT_RST_W = `CCF_POINT_RST;
  localparam [CNT_W-1:0] POINT_RST   = POINT_RST_W[CNT_W-1:0];

  // Register selector codes from the address decode
  localparam [2:0] SEL_NONE    = 3'h0;
  localparam [2:0] SEL_CTRL    = 3'h1;
  localparam [2:0] SEL_POINT1  = 3'h2;
  localparam [2:0] SEL_POINT2  = 3'h3;
  localparam [2:0] SEL_STATUS  = 3'h4;
  localparam [2:0] SEL_HOLDERR = 3'h5;

  // Address decode shared by read and write paths
  function [2:0] regSel;
    input [7:0] addr;
    begin
      case (addr)
        `CCF_CTRL_OFS:    regSel = SEL_CTRL;
        `CCF_POINT1_OFS:  regSel = SEL_POINT1;
        `CCF_POINT2_OFS:  regSel = SEL_POINT2;
        `CCF_STATUS_OFS:  regSel = SEL_STATUS;
        `CCF_HOLDERR_OFS: regSel = SEL_HOLDERR;
        default:          regSel = SEL_NONE;
      endcase
    end
  endfunction

  reg  [CW-1:0]    ctrl_q;
  reg  [CW-1:0]    ctrlPrev_q;
  reg  [CNT_W-1:0] point1_q;
  reg  [CNT_W-1:0] point2_q;
  reg  [CW-1:0]    holdErr_q;
  reg  [CW-1:0]    holdErr_d;
  reg              zSync1_q;
  reg              zSync2_q;
  reg              zPrev_q;
  reg              zPending_q;
  reg              zClrPending_q;
  reg              fClrPending_q;
  wire [2:0]       wSel;
  wire [2:0]       rSel;
  wire             wrFire;
  wire             wrCtrl;
  wire             wrPoint1;
  wire             wrPoint2;
  wire             wrHoldClr;
  wire [CW-1:0]    cmdRise;
  wire [CW-1:0]    cmdEdge;
  wire [31:0]      statusWord;
  reg  [31:0]      rdData;

  assign wSel   = regSel(paddr);
  assign rSel   = regSel(paddr);
  assign wrFire = psel & penable & pready & pwrite;
  assign cmdRise = ctrl_q & ~ctrlPrev_q;
  assign cmdEdge = ctrl_q ^ ctrlPrev_q;

  // One write strobe per register; STATUS and unmapped writes are dropped
  assign wrCtrl    = wrFire & (wSel == SEL_CTRL);
  assign wrPoint1  = wrFire & (wSel == SEL_POINT1);
  assign wrPoint2  = wrFire & (wSel == SEL_POINT2);
  assign wrHoldClr = wrFire & (wSel == SEL_HOLDERR);

  // Status word as seen by software
  assign statusWord = {23'h000000,
                       ch2WarningFlag,
                       ch2FaultFlag,
                       ch2ZPhasePresetSeenFlag,
                       ch2BelowPoint2Flag,
                       ch2MatchPoint2Flag,
                       ch2AbovePoint2Flag,
                       ch2BelowPoint1Flag,
                       ch2MatchPoint1Flag,
                       ch2AbovePoint1Flag};

  // APB handshake: one wait state, answer registered
  always @(posedge core_clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (rSel == SEL_NONE);
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rdData;
    end
  end

  // Read multiplexer; narrow registers read zero above
  always @* begin
    rdData = 32'h00000000;
    case (rSel)
      SEL_CTRL:    rdData[CW-1:0]    = ctrl_q;
      SEL_POINT1:  rdData[CNT_W-1:0] = point1_q;
      SEL_POINT2:  rdData[CNT_W-1:0] = point2_q;
      SEL_STATUS:  rdData            = statusWord;
      SEL_HOLDERR: rdData[CW-1:0]    = holdErr_q;
      default:     rdData            = 32'h00000000;
    endcase
  end

  // Writable registers: commands and coincidence points
  always @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q     <= `CCF_CTRL_RST;
      ctrlPrev_q <= `CCF_CTRL_RST;
      point1_q   <= POINT_RST;
      point2_q   <= POINT_RST;
    end else begin
      ctrlPrev_q <= ctrl_q;
      if (wrCtrl)
        ctrl_q <= pwdata[CW-1:0];
      if (wrPoint1)
        point1_q <= pwdata[CNT_W-1:0];
      if (wrPoint2)
        point2_q <= pwdata[CNT_W-1:0];
    end
  end

  // Channel 1 outputs: level run, edge-only fault clear
  always @(posedge core_clk) begin
    if (!resetn) begin
      ch1MeasureRun      <= 1'b0;
      ch1FaultClearPulse <= 1'b0;
    end else begin
      ch1MeasureRun      <= ctrl_q[`CCF_CMD_MEAS1];
      ch1FaultClearPulse <= cmdRise[`CCF_CMD_FCLR1];
    end
  end

  // Hold-time watch: a command bit that changes again before the
  // least hold time sets a sticky error bit; the core still obeys it
  genvar gi;
  generate
    for (gi = 0; gi < CW; gi = gi + 1) begin : gHold
      // Saturating count, so long idle times need no wider counter
      reg [HW-1:0] holdCnt_q;
      always @(posedge core_clk) begin
        if (!resetn)
          holdCnt_q <= HOLD_MAX;
        else if (cmdEdge[gi])
          holdCnt_q <= 16'h0001;
        else if (holdCnt_q < HOLD_MAX)
          holdCnt_q <= holdCnt_q + 16'h0001;
      end
      // Short on or off times are flagged
      always @* begin
        holdErr_d[gi] = holdErr_q[gi];
        if (wrHoldClr && pwdata[gi])
          holdErr_d[gi] = 1'b0;
        if (cmdEdge[gi] && holdCnt_q < HOLD_MAX)
          holdErr_d[gi] = 1'b1;
      end
    end
  endgenerate

  // Sticky hold errors, write one to clear, set wins
  always @(posedge core_clk) begin
    if (!resetn)
      holdErr_q <= {CW{1'b0}};
    else
      holdErr_q <= holdErr_d;
  end

  // Coincidence points one and two
  cmp_point #(
    .CNT_W      (CNT_W)
  ) uPoint1 (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .curValue   (ch2CountValue),
    .pointValue (point1_q),
    .scanEnd    (scanEnd),
    .matchClear (ctrl_q[`CCF_CMD_MCLR1]),
    .aboveFlag  (ch2AbovePoint1Flag),
    .matchFlag  (ch2MatchPoint1Flag),
    .belowFlag  (ch2BelowPoint1Flag)
  );

  cmp_point #(
    .CNT_W      (CNT_W)
  ) uPoint2 (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .curValue   (ch2CountValue),
    .pointValue (point2_q),
    .scanEnd    (scanEnd),
    .matchClear (ctrl_q[`CCF_CMD_MCLR2]),
    .aboveFlag  (ch2AbovePoint2Flag),
    .matchFlag  (ch2MatchPoint2Flag),
    .belowFlag  (ch2BelowPoint2Flag)
  );

  // Phase-Z pin synchroniser; only the second stage is looked at
  always @(posedge core_clk) begin
    if (!resetn) begin
      zSync1_q <= 1'b0;
      zSync2_q <= 1'b0;
      zPrev_q  <= 1'b0;
    end else begin
      zSync1_q <= ch2ZPhasePin;
      zSync2_q <= zSync1_q;
      zPrev_q  <= zSync2_q;
    end
  end

  // Preset request: caught at once, shown at the next scan end
  always @(posedge core_clk) begin
    if (!resetn) begin
      zPending_q              <= 1'b0;
      zClrPending_q           <= 1'b0;
      ch2ZPhasePresetSeenFlag <= 1'b0;
    end else begin
      if (scanEnd)
        zPending_q <= zSync2_q & ~zPrev_q;
      else if (zSync2_q & ~zPrev_q)
        zPending_q <= 1'b1;
      if (scanEnd)
        zClrPending_q <= cmdRise[`CCF_CMD_ZCLR2];
      else if (cmdRise[`CCF_CMD_ZCLR2])
        zClrPending_q <= 1'b1;
      // New request beats a clear in the same scan
      if (scanEnd) begin
        if (zPending_q)
          ch2ZPhasePresetSeenFlag <= 1'b1;
        else if (zClrPending_q)
          ch2ZPhasePresetSeenFlag <= 1'b0;
      end
    end
  end

  // Fault and warning: reset edge remembered until next scan end
  always @(posedge core_clk) begin
    if (!resetn) begin
      fClrPending_q  <= 1'b0;
      ch2FaultFlag   <= 1'b0;
      ch2WarningFlag <= 1'b0;
    end else begin
      if (scanEnd)
        fClrPending_q <= cmdRise[`CCF_CMD_FCLR2];
      else if (cmdRise[`CCF_CMD_FCLR2])
        fClrPending_q <= 1'b1;
      if (scanEnd) begin
        // A live cause keeps the flag set whatever the reset does
        if (ch2FaultCause)
          ch2FaultFlag <= 1'b1;
        else if (fClrPending_q)
          ch2FaultFlag <= 1'b0;
        if (ch2WarnCause)
          ch2WarningFlag <= 1'b1;
        else if (fClrPending_q)
          ch2WarningFlag <= 1'b0;
      end
    end
  end

endmodule // counter_compare_flags

/* File: verification/counter_compare_flags_asserts.sv */
// Port checker for counter_compare_flags.
// Assumes one clock; CTRL sits at byte address 0x00.
`timescale 1ns/1ps
module counter_compare_flags_asserts (
  // Clock and reset
  input logic        core_clk,
  input logic        resetn,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  // Counter side
  input logic        scanEnd,
  input logic        ch2FaultCause,
  // Outputs
  input logic        ch1MeasureRun,
  input logic        ch1FaultClearPulse,
  input logic        ch2AbovePoint1Flag,
  input logic        ch2MatchPoint1Flag,
  input logic        ch2BelowPoint1Flag,
  input logic        ch2MatchPoint2Flag,
  input logic        ch2ZPhasePresetSeenFlag,
  input logic        ch2FaultFlag
);
  logic [5:0] ctrl_q;
  logic [1:0] age_q;
  wire        ctrlWr = psel & penable & pready & pwrite & (paddr == 8'h00);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // CTRL shadow and its age, saturating so idle time is cheap
  always @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= 6'h00;
      age_q  <= 2'h3;
    end else if (ctrlWr && pwdata[5:0] != ctrl_q) begin
      ctrl_q <= pwdata[5:0];
      age_q  <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  chk_measure_follows: assert property (
    age_q >= 2'h2 |-> ch1MeasureRun == ctrl_q[0])
    else $error("measure run differs from command");
  chk_clear_on_rise: assert property (
    $rose(ctrl_q[1]) |-> ##[0:2] ch1FaultClearPulse)
    else $error("no clear pulse after rise");
  chk_clear_only_rise: assert property (
    ch1FaultClearPulse |-> ctrl_q[1] && age_q != 2'h3 ##1 !ch1FaultClearPulse)
    else $error("clear pulse without fresh rise");
  chk_above_below_excl: assert property (
    !(ch2AbovePoint1Flag && ch2BelowPoint1Flag))
    else $error("above and below both set");
  chk_match1_sticks: assert property (
    ch2MatchPoint1Flag && !ctrl_q[3] |=> ch2MatchPoint1Flag)
    else $error("match1 dropped without clear");
  chk_match2_sticks: assert property (
    ch2MatchPoint2Flag && !ctrl_q[4] |=> ch2MatchPoint2Flag)
    else $error("match2 dropped without clear");
  chk_fault_sets: assert property (
    scanEnd && ch2FaultCause |=> ch2FaultFlag)
    else $error("fault flag not set at scan end");
  chk_scan_refresh: assert property (
    !scanEnd |=> $stable({ch2AbovePoint1Flag, ch2BelowPoint1Flag,
                          ch2ZPhasePresetSeenFlag, ch2FaultFlag}))
    else $error("flag moved between scan ends");
  chk_one_wait: assert property (
    psel && !penable |=> ##1 pready)
    else $error("ready not after one wait");
  chk_err_with_ready: assert property (
    pslverr |-> pready ##1 !pready)
    else $error("error without single ready");
  cover property (ch2MatchPoint1Flag && ctrl_q[3]);
  cover property (ch2FaultFlag ##1 !ch2FaultFlag);
  cover property (pslverr);
endmodule // counter_compare_flags_asserts

bind counter_compare_flags counter_compare_flags_asserts i_chk (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .scanEnd(scanEnd), .ch2FaultCause(ch2FaultCause),
  .ch1MeasureRun(ch1MeasureRun), .ch1FaultClearPulse(ch1FaultClearPulse),
  .ch2AbovePoint1Flag(ch2AbovePoint1Flag),
  .ch2MatchPoint1Flag(ch2MatchPoint1Flag),
  .ch2BelowPoint1Flag(ch2BelowPoint1Flag),
  .ch2MatchPoint2Flag(ch2MatchPoint2Flag),
  .ch2ZPhasePresetSeenFlag(ch2ZPhasePresetSeenFlag),
  .ch2FaultFlag(ch2FaultFlag));

/* File: verification/scan_pacer.sv */
// Scan loop model: one end-of-scan pulse every PERIOD cycles.
// Assumes the core clock and its synchronous reset.
`timescale 1ns/1ps
module scan_pacer #(
  parameter int PERIOD = 4
) (
  // Clock and reset
  input  logic core_clk,
  input  logic resetn,
  // Scan step
  output logic scanEnd
);
  int count_q;
  // Short scan keeps the run brief
  always @(posedge core_clk) begin
    if (!resetn) begin
      count_q <= 0;
      scanEnd <= 1'b0;
    end else begin
      count_q <= (count_q == PERIOD - 1) ? 0 : count_q + 1;
      scanEnd <= (count_q == PERIOD - 1);
    end
  end
endmodule // scan_pacer

/* File: verification/counter_compare_flags_test.sv */
// Self-checking bench for counter_compare_flags with a flag model.
// Assumes scan_pacer for scan ends and a short command hold time.
`timescale 1ns/1ps
module counter_compare_flags_test;
  localparam int HOLD = 8;
  logic        core_clk, resetn, psel, penable, pwrite, err;
  logic        fCause, wCause, zPin;
  logic [7:0]  paddr, cnt;
  logic [31:0] pwdata, rd;
  logic [5:0]  mCtrl, mFlags;
  wire  [31:0] prdata;
  wire         pready, pslverr, scanEnd, measRun, clrPulse;
  wire         ab1, m1, bl1, ab2, m2, bl2, zSeen, fault, warn;
  int          mismatches, compares, cycles, pulses, mP1, mP2;

  counter_compare_flags #(.CNT_W(8), .HOLD_CYC(HOLD)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch2CountValue(cnt),
    .ch2FaultCause(fCause), .ch2WarnCause(wCause), .ch2ZPhasePin(zPin),
    .scanEnd(scanEnd), .ch1MeasureRun(measRun),
    .ch1FaultClearPulse(clrPulse), .ch2AbovePoint1Flag(ab1),
    .ch2MatchPoint1Flag(m1), .ch2BelowPoint1Flag(bl1),
    .ch2AbovePoint2Flag(ab2), .ch2MatchPoint2Flag(m2),
    .ch2BelowPoint2Flag(bl2), .ch2ZPhasePresetSeenFlag(zSeen),
    .ch2FaultFlag(fault), .ch2WarningFlag(warn));
  scan_pacer #(.PERIOD(4)) i_scan (
    .core_clk(core_clk), .resetn(resetn), .scanEnd(scanEnd));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Random count in a narrow range so both points are hit often
  always @(posedge core_clk) begin
    cnt <= resetn ? 8'($urandom_range(7, 0)) : 8'h00;
    pulses <= pulses + int'(clrPulse);
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end
  // Flag model snooping the bus; bits above1..below2 from high to low
  always @(posedge core_clk) begin
    if (!resetn) begin
      mCtrl <= 6'h00;
      mFlags <= 6'h00;
      mP1 <= 0;
      mP2 <= 0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 8'h00)
        mCtrl <= pwdata[5:0];
      if (psel && penable && pready && pwrite && paddr == 8'h04) mP1 <= pwdata;
      if (psel && penable && pready && pwrite && paddr == 8'h08) mP2 <= pwdata;
      if (scanEnd) begin
        mFlags[5] <= cnt > mP1;
        mFlags[3] <= cnt < mP1;
        mFlags[2] <= cnt > mP2;
        mFlags[0] <= cnt < mP2;
      end
      if (cnt == mP1) mFlags[4] <= 1'b1;
      else if (mCtrl[3]) mFlags[4] <= 1'b0;
      if (cnt == mP2) mFlags[1] <= 1'b1;
      else if (mCtrl[4]) mFlags[1] <= 1'b0;
    end
  end
  always @(negedge core_clk) begin
    if (resetn) chk({ab1, m1, bl1, ab2, m2, bl2}, mFlags);
  end

  initial begin
    {resetn, psel, penable, pwrite, fCause, wCause, zPin} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {mismatches, compares, cycles, pulses} = '0;
    void'($urandom(32'hce7e));
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk({measRun, clrPulse, zSeen, fault, warn}, 0);
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h00000000, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    $display("done: points and bus");
    apb(1'b1, 8'h00, 32'h18);
    repeat (HOLD + 4) @(posedge core_clk);
    apb(1'b1, 8'h00, 32'h0);
    repeat (20) @(posedge core_clk);
    $display("done: match clear");
    apb(1'b1, 8'h00, 32'h3);
    repeat (HOLD + 4) @(posedge core_clk);
    chk({measRun, pulses[3:0]}, 5'h11);
    apb(1'b1, 8'h00, 32'h0);
    repeat (HOLD + 4) @(posedge core_clk);
    apb(1'b1, 8'h00, 32'h2);
    repeat (HOLD + 4) @(posedge core_clk);
    chk({measRun, pulses[3:0]}, 5'h02);
    $display("done: channel 1 commands");
    fCause <= 1'b1;
    wCause <= 1'b1;
    zPin <= 1'b1;
    apb(1'b1, 8'h00, 32'h4);
    repeat (HOLD + 4) @(posedge core_clk);
    chk({zSeen, fault, warn}, 3'h7);
    apb(1'b1, 8'h00, 32'h0);
    {fCause, wCause, zPin} <= 3'h0;
    repeat (HOLD + 4) @(posedge core_clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd[8:6], 3'h7);
    apb(1'b1, 8'h00, 32'h24);
    repeat (HOLD + 4) @(posedge core_clk);
    chk({zSeen, fault, warn}, 3'h0);
    $display("done: fault, warning and preset request");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b1, 8'h00, 32'h25);
    apb(1'b1, 8'h00, 32'h24);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h00000000);
    $display("done: hold-time watch");
    summarize();
  end
endmodule // counter_compare_flags_test
